// [src/asu_map.svh]
`ifndef ASU_MAP_SVH
`define ASU_MAP_SVH

// Register byte addresses on the APB.
`define ASU_ADDR_BAUD 8'h00
`define ASU_ADDR_CONFIG 8'h04
`define ASU_ADDR_FLAG 8'h08
`define ASU_ADDR_DATA 8'h0C
`define ASU_ADDR_COMBO 8'h10

// Field widths.
`define ASU_DIV_W 13
`define ASU_CFG_W 9
`define ASU_FLG_W 5
`define ASU_DAT_W 9

// serial_config_reg bit positions.
`define ASU_CFG_TXEN 0
`define ASU_CFG_RXEN 1
`define ASU_CFG_ODD 2
`define ASU_CFG_PEN 3
`define ASU_CFG_LONG 4
`define ASU_CFG_WAKE 5
`define ASU_CFG_TIE 6
`define ASU_CFG_TCIE 7
`define ASU_CFG_RIE 8

// serial_flag_reg bit positions and groups.
`define ASU_FLG_PERR 0
`define ASU_FLG_OVR 1
`define ASU_FLG_RXF 2
`define ASU_FLG_DONE 3
`define ASU_FLG_TXE 4
`define ASU_FLG_RX_MASK 5'h07
`define ASU_FLG_TX_MASK 5'h18

// Reset values.
`define ASU_BAUD_RST 13'h0000
`define ASU_CFG_RST 9'h000
`define ASU_FLG_RST 5'h18

// Bit timing in sampling-clock ticks, frame lengths in bits, payload masks.
`define ASU_PHASE_LAST 4'hF
`define ASU_VOTE_FIRST 4'h7
`define ASU_VOTE_LAST 4'h9
`define ASU_SYNC_EARLY 4'h5
`define ASU_SYNC_LATE 4'hB
`define ASU_LEN_SHORT 4'hA
`define ASU_LEN_LONG 4'hB
`define ASU_MASK_SHORT 9'h0FF
`define ASU_MASK_LONG 9'h1FF
`define ASU_MASK_SHORT_PAR 9'h07F

`endif

// [src/asu_pkg.sv]
`default_nettype none
`include "asu_map.svh"

package asu_pkg;

    typedef enum logic [0:0] {
        ASU_TX_IDLE = 1'b0,
        ASU_TX_SHIFT = 1'b1
    } asu_tx_state_t;

    typedef enum logic [0:0] {
        ASU_RX_IDLE = 1'b0,
        ASU_RX_BUSY = 1'b1
    } asu_rx_state_t;

    typedef struct packed {
        logic [`ASU_DIV_W-1:0] baud;
        logic [`ASU_CFG_W-1:0] cfg;
        logic [`ASU_FLG_W-1:0] flags;
        logic [`ASU_FLG_W-1:0] arm;
        logic [31:0] prdata;
        logic [`ASU_DIV_W:0] div_cnt;
        asu_tx_state_t tx_st;
        logic [`ASU_DAT_W-1:0] tx_hold;
        logic [10:0] tx_sh;
        logic [3:0] tx_bit;
        logic [3:0] tx_phase;
        logic tx_out;
        asu_rx_state_t rx_st;
        logic [2:0] rx_hist;
        logic rx_prev;
        logic [3:0] rx_phase;
        logic [3:0] rx_bit;
        logic [1:0] rx_votes;
        logic [`ASU_DAT_W-1:0] rx_sh;
        logic [`ASU_DAT_W-1:0] rx_hold;
        logic irq;
    } asu_state_t;

endpackage : asu_pkg

`default_nettype wire

// [src/asu_top.sv]
// Added by the designer: the APB register port and the register addresses.
`default_nettype none
`include "asu_map.svh"

// Functional notes
// [RQ1] Baud equals clock over thirty-two times divisor.
// [RQ2] Zero divisor stops all baud ticks.
// [RQ3] Sampling tick runs sixteen times baud rate.
// [RQ4] Edges realign the receive bit phase.
// [RQ5] Start needs three ones then a low.
// [RQ6] Frames are ten or eleven bits long.
// [RQ7] Length and parity choose data bit count.
// [RQ8] Odd select sets parity for both directions.
// [RQ9] Top payload bit carries generated/checked parity.
// [RQ10] Parity mismatch sets the parity error flag.
// [RQ11] Idle lines ignored; stopless frames are dropped.
// [RQ12] Flags clear by status read then data access.
// [RQ13] Combined read clears receive flags only.
// [RQ14] Flags set after the status read stay.
// [RQ15] A status read arms only the flag bits set at that read.
// [RQ16] Data address reads receive, writes transmit holding.
// [RQ17] Ninth bit ignored in eight-bit modes.
// [RQ18] Transmit pin is GPIO while transmitter disabled; a frame in progress at disable still finishes on the pin first.
// [RQ19] Control registers are readable and writable anytime.
// [RQ20] Software programs divisor before enabling.
// [RQ21] Software disables before changing control bits.
// [RQ22] Enable bits gate flags onto request output.
// [RQ23] Shifter load sets transmit holding empty.
// [RQ24] Good stop bit fills receive holding register.
// [RQ25] Full holding blocks transfer and flags overrun.
// [RQ26] Majority of three mid-bit samples decides value.
module asu_top
    import asu_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic RXD_I,
    input wire logic GPIO_TXD_I,
    output logic TXD_O,
    output logic IRQ_O
);

    asu_state_t q;
    asu_state_t d;

    function automatic logic [`ASU_DAT_W-1:0] payload_mask(input logic long_f);
        payload_mask = long_f ? `ASU_MASK_LONG : `ASU_MASK_SHORT;
    endfunction : payload_mask

    function automatic logic [10:0] build_frame(input logic [`ASU_DAT_W-1:0] dat,
                                                input logic long_f, input logic pen,
                                                input logic odd);
        logic [`ASU_DAT_W-1:0] p;
        p = long_f ? dat : {1'b1, dat[7:0]};
        if (pen && long_f) begin
            p[8] = (^(dat & `ASU_MASK_SHORT)) ^ odd; // [RQ8] [RQ9]
        end else if (pen) begin
            p[7] = (^(dat & `ASU_MASK_SHORT_PAR)) ^ odd; // [RQ8] [RQ9]
        end
        build_frame = {1'b1, p, 1'b0}; // [RQ6]
    endfunction : build_frame

    function automatic logic [31:0] read_value(input asu_state_t s, input logic [7:0] a,
                                               input logic long_f);
        logic [15:0] dat;
        dat = {7'h00, long_f ? s.rx_hold[8] : 1'b0, s.rx_hold[7:0]}; // [RQ16] [RQ17]
        if (a == `ASU_ADDR_BAUD) begin
            read_value = {19'h00000, s.baud};
        end else if (a == `ASU_ADDR_CONFIG) begin
            read_value = {23'h000000, s.cfg}; // [RQ19]
        end else if (a == `ASU_ADDR_FLAG) begin
            read_value = {27'h0000000, s.flags};
        end else if (a == `ASU_ADDR_DATA) begin
            read_value = {16'h0000, dat};
        end else if (a == `ASU_ADDR_COMBO) begin
            read_value = {dat, 11'h000, s.flags}; // [RQ13]
        end else begin
            read_value = 32'h00000000;
        end
    endfunction : read_value

    logic mapped;
    logic setup;
    logic access;
    logic tick;
    logic long_f;
    logic pen;
    logic odd;
    logic rx_bit_v;
    logic rx_edge;
    logic [3:0] frame_len;
    logic [`ASU_FLG_W-1:0] set_v;
    logic [`ASU_FLG_W-1:0] clr_v;

    always_comb begin
        d = q;
        set_v = 5'h00;
        clr_v = 5'h00;
        long_f = q.cfg[`ASU_CFG_LONG];
        pen = q.cfg[`ASU_CFG_PEN];
        odd = q.cfg[`ASU_CFG_ODD];
        frame_len = long_f ? `ASU_LEN_LONG : `ASU_LEN_SHORT; // [RQ6] [RQ7]
        mapped = (PADDR_I == `ASU_ADDR_BAUD) || (PADDR_I == `ASU_ADDR_CONFIG) ||
                 (PADDR_I == `ASU_ADDR_FLAG) || (PADDR_I == `ASU_ADDR_DATA) ||
                 (PADDR_I == `ASU_ADDR_COMBO);
        setup = PSEL_I && !PENABLE_I;
        access = PSEL_I && PENABLE_I;
        rx_bit_v = 1'b0;
        rx_edge = 1'b0;

        // Baud generator: one sampling tick every 2*divisor clocks.
        tick = 1'b0;
        if (q.baud == 13'h0000) begin
            d.div_cnt = 14'h0000; // [RQ2]
        end else if (q.div_cnt == 14'h0000) begin
            tick = 1'b1; // [RQ3]
            d.div_cnt = {q.baud, 1'b0} - 14'h0001; // [RQ1]
        end else begin
            d.div_cnt = q.div_cnt - 14'h0001;
        end

        // Register bus.
        if (setup && !PWRITE_I) begin
            d.prdata = read_value(q, PADDR_I, long_f);
        end
        if (access && PWRITE_I) begin
            if (PADDR_I == `ASU_ADDR_BAUD) begin
                d.baud = PWDATA_I[`ASU_DIV_W-1:0];
            end else if (PADDR_I == `ASU_ADDR_CONFIG) begin
                d.cfg = PWDATA_I[`ASU_CFG_W-1:0]; // [RQ19]
            end else if (PADDR_I == `ASU_ADDR_DATA) begin
                d.tx_hold = {long_f & PWDATA_I[8], PWDATA_I[7:0]}; // [RQ16] [RQ17]
                clr_v = q.arm & `ASU_FLG_TX_MASK; // [RQ12]
                d.arm = q.arm & ~`ASU_FLG_TX_MASK;
            end
        end else if (access) begin
            if (PADDR_I == `ASU_ADDR_FLAG) begin
                d.arm = q.prdata[`ASU_FLG_W-1:0]; // [RQ12] [RQ14] [RQ15]
            end else if (PADDR_I == `ASU_ADDR_DATA) begin
                clr_v = q.arm & `ASU_FLG_RX_MASK; // [RQ12]
                d.arm = q.arm & ~`ASU_FLG_RX_MASK;
            end else if (PADDR_I == `ASU_ADDR_COMBO) begin
                clr_v = q.prdata[`ASU_FLG_W-1:0] & `ASU_FLG_RX_MASK; // [RQ13]
                d.arm = q.arm & ~`ASU_FLG_RX_MASK;
            end
        end

        // Transmitter.
        case (q.tx_st)
            ASU_TX_IDLE: begin
                if (tick && q.cfg[`ASU_CFG_TXEN] && !q.flags[`ASU_FLG_TXE]) begin // [RQ2]
                    d.tx_sh = build_frame(q.tx_hold, long_f, pen, odd);
                    set_v[`ASU_FLG_TXE] = 1'b1; // [RQ23]
                    d.tx_bit = 4'h0;
                    d.tx_phase = 4'h0;
                    d.tx_st = ASU_TX_SHIFT;
                end
            end
            ASU_TX_SHIFT: begin
                if (tick) begin
                    d.tx_phase = q.tx_phase + 4'h1;
                    if (q.tx_phase == `ASU_PHASE_LAST) begin
                        d.tx_sh = {1'b1, q.tx_sh[10:1]};
                        d.tx_bit = q.tx_bit + 4'h1;
                        if (q.tx_bit == frame_len - 4'h1) begin
                            if (q.cfg[`ASU_CFG_TXEN] && !q.flags[`ASU_FLG_TXE]) begin
                                d.tx_sh = build_frame(q.tx_hold, long_f, pen, odd);
                                set_v[`ASU_FLG_TXE] = 1'b1; // [RQ23]
                                d.tx_bit = 4'h0;
                            end else begin
                                set_v[`ASU_FLG_DONE] = 1'b1;
                                d.tx_st = ASU_TX_IDLE;
                            end
                        end
                    end
                end
            end
            default: begin
                d.tx_st = ASU_TX_IDLE;
            end
        endcase
        if (d.tx_st == ASU_TX_SHIFT) begin
            d.tx_out = d.tx_sh[0]; // [RQ1]
        end else if (q.cfg[`ASU_CFG_TXEN]) begin
            d.tx_out = 1'b1;
        end else begin
            d.tx_out = GPIO_TXD_I; // [RQ18]
        end

        // Receiver.
        if (!q.cfg[`ASU_CFG_RXEN]) begin
            d.rx_st = ASU_RX_IDLE; // [RQ18]
            d.rx_hist = 3'h0;
        end else if (tick) begin
            d.rx_hist = {q.rx_hist[1:0], RXD_I};
            d.rx_prev = RXD_I;
            rx_edge = RXD_I != q.rx_prev;
            case (q.rx_st)
                ASU_RX_IDLE: begin
                    if (!RXD_I && q.rx_hist == 3'h7) begin
                        d.rx_st = ASU_RX_BUSY; // [RQ5] [RQ11]
                        d.rx_phase = 4'h0;
                        d.rx_bit = 4'h0;
                        d.rx_sh = 9'h000;
                    end
                end
                ASU_RX_BUSY: begin
                    d.rx_phase = q.rx_phase + 4'h1;
                    if (q.rx_phase == `ASU_PHASE_LAST) begin
                        d.rx_bit = q.rx_bit + 4'h1;
                    end
                    if (rx_edge && q.rx_bit != 4'h0) begin
                        if (q.rx_phase > `ASU_SYNC_LATE) begin
                            d.rx_phase = 4'h0; // [RQ4]
                            d.rx_bit = q.rx_bit + 4'h1;
                        end else if (q.rx_phase < `ASU_SYNC_EARLY) begin
                            d.rx_phase = 4'h0; // [RQ4]
                        end
                    end
                    if (q.rx_phase >= `ASU_VOTE_FIRST && q.rx_phase < `ASU_VOTE_LAST) begin
                        d.rx_votes = {q.rx_votes[0], RXD_I};
                    end
                    if (q.rx_phase == `ASU_VOTE_LAST) begin
                        rx_bit_v = (q.rx_votes[1] & q.rx_votes[0]) |
                                   (q.rx_votes[1] & RXD_I) |
                                   (q.rx_votes[0] & RXD_I); // [RQ26]
                        if (q.rx_bit == 4'h0) begin
                            if (rx_bit_v) begin
                                d.rx_st = ASU_RX_IDLE;
                            end
                        end else if (q.rx_bit == frame_len - 4'h1) begin
                            d.rx_st = ASU_RX_IDLE;
                            if (!rx_bit_v) begin
                                d.rx_st = ASU_RX_IDLE; // [RQ11]
                            end else if (q.flags[`ASU_FLG_RXF]) begin
                                set_v[`ASU_FLG_OVR] = 1'b1; // [RQ25]
                            end else begin
                                d.rx_hold = q.rx_sh; // [RQ24]
                                set_v[`ASU_FLG_RXF] = 1'b1; // [RQ24]
                                set_v[`ASU_FLG_PERR] = pen &&
                                    ((^(q.rx_sh & payload_mask(long_f))) != odd); // [RQ10]
                            end
                        end else begin
                            d.rx_sh[q.rx_bit - 4'h1] = rx_bit_v; // [RQ6]
                        end
                    end
                end
                default: begin
                    d.rx_st = ASU_RX_IDLE;
                end
            endcase
        end

        // A flag set in the cycle of its clear stays set.
        d.flags = (q.flags & ~clr_v) | set_v; // [RQ12] [RQ14]
        d.irq = (q.flags[`ASU_FLG_TXE] & q.cfg[`ASU_CFG_TIE]) |
                (q.flags[`ASU_FLG_DONE] & q.cfg[`ASU_CFG_TCIE]) |
                ((q.flags[`ASU_FLG_RXF] | q.flags[`ASU_FLG_OVR]) &
                 q.cfg[`ASU_CFG_RIE]); // [RQ22]
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            q <= '0;
            q.baud <= `ASU_BAUD_RST;
            q.cfg <= `ASU_CFG_RST;
            q.flags <= `ASU_FLG_RST;
            q.tx_st <= ASU_TX_IDLE;
            q.rx_st <= ASU_RX_IDLE;
            q.tx_out <= 1'b1;
            q.rx_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign PRDATA_O = q.prdata;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
    assign TXD_O = q.tx_out;
    assign IRQ_O = q.irq;

endmodule : asu_top

`default_nettype wire

// [tb/asu_checker.sv]
`default_nettype none
module asu_checker (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic TXD_O,
    input wire logic IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] div_q;
    logic [8:0] cfg_q;
    logic [19:0] run_q;
    logic wr;
    assign wr = PSEL_I && PENABLE_I && PWRITE_I;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            div_q <= 13'h0000;
            cfg_q <= 9'h000;
            run_q <= 20'h00000;
        end else begin
            if (wr && PADDR_I == 8'h00) div_q <= PWDATA_I[12:0];
            if (wr && PADDR_I == 8'h04) cfg_q <= PWDATA_I[8:0];
            run_q <= $changed(TXD_O) ? 20'h00000 : run_q + 20'h00001;
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_rd(a);
        PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == a ##1 PSEL_I && PENABLE_I;
    endsequence
    AST_READY: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
        else $error("access without ready");
    AST_SLVERR: assert property (PSEL_I && PENABLE_I |->
        PSLVERR_O == (PADDR_I > 8'h10 || PADDR_I[1:0] != 2'h0))
        else $error("wrong error response");
    AST_HOLD: assert property (!(PSEL_I && !PENABLE_I && !PWRITE_I) |=>
        $stable(PRDATA_O)) else $error("read data moved");
    AST_FLAGW: assert property (s_rd(8'h08) |-> PRDATA_O[31:5] == 27'h0)
        else $error("flag word has stray bits");
    AST_DATAW: assert property (s_rd(8'h0C) |->
        PRDATA_O[31:9] == 23'h0 && (cfg_q[4] || !PRDATA_O[8]))
        else $error("data word has stray bits");
    AST_COMBO: assert property (s_rd(8'h10) |->
        PRDATA_O[31:25] == 7'h0 && PRDATA_O[15:5] == 11'h0)
        else $error("combined word has stray bits");
    AST_DIV0: assert property (div_q == 13'h0 && $past(div_q) == 13'h0 &&
        cfg_q[0] && $past(cfg_q[0]) |=> $stable(TXD_O))
        else $error("line moved with divisor zero");
    AST_BITLEN: assert property ($rose(TXD_O) && cfg_q[0] && $past(cfg_q[0]) &&
        div_q != 13'h0 |-> run_q >= 20'({div_q, 5'h00}) - 20'h00001)
        else $error("low bit too short");
    AST_IRQOFF: assert property (cfg_q[8:6] == 3'h0 &&
        $past(cfg_q[8:6]) == 3'h0 |-> !IRQ_O) else $error("request while masked");
endmodule : asu_checker
bind asu_top asu_checker u_asu_checker (
    .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TXD_O(TXD_O), .IRQ_O(IRQ_O)
);
`default_nettype wire

// [tb/asu_serial_peer.sv]
`default_nettype none
module asu_serial_peer (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int div = 1;
    initial rxd_o = 1'b1;
    task automatic send(input logic [10:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            rxd_o <= f[i];
            repeat (32 * div) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
    endtask : send
    task automatic get(input int n, output logic [10:0] f);
        f = 11'h000;
        @(negedge txd_i);
        repeat (16 * div) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            f[i] = txd_i;
            repeat (32 * div) @(posedge clk_i);
        end
    endtask : get
endmodule : asu_serial_peer
`default_nettype wire

// [tb/async_serial_interface_tb.sv]
`default_nettype none
`include "asu_map.svh"
module async_serial_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, psel, pen, pwr, gpio, pready, slverr, serr, txd, rxd, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [10:0] got;
    int mismatches = 0;
    int n_checks = 0;
    asu_top u_asu_top (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(slverr), .RXD_I(rxd), .GPIO_TXD_I(gpio),
        .TXD_O(txd), .IRQ_O(irq));
    asu_serial_peer u_asu_serial_peer (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        serr = slverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : xfer
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask : rdchk
    function automatic logic [10:0] frm(input logic [8:0] d, input logic [2:0] m);
        logic [8:0] p;
        logic [10:0] f;
        int w;
        w = m[2] ? 9 : 8;
        p = d & 9'((1 << (w - m[1])) - 1);
        if (m[1]) p[w - 1] = ^p ^ m[0];
        f = {2'b00, p} << 1;
        f[w + 1] = 1'b1;
        return f;
    endfunction : frm
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        #600us;
        mismatches++;
        wrap_up();
    end
    initial begin
        rst = 1'b1;
        {psel, pen, pwr, paddr, pwdata} = '0;
        gpio = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(`ASU_ADDR_BAUD, 32'h0);
        rdchk(`ASU_ADDR_CONFIG, 32'h0);
        rdchk(`ASU_ADDR_FLAG, 32'h18);
        xfer(1'b0, 8'h14, 32'h0);
        chk(serr, 32'h1);
        gpio <= 1'b0;
        repeat (2) @(posedge clk);
        chk(txd, 32'h0);
        gpio <= 1'b1;
        xfer(1'b1, `ASU_ADDR_BAUD, 32'h1);
        rdchk(`ASU_ADDR_BAUD, 32'h1);
        for (int m = 0; m < 8; m++) begin
            xfer(1'b1, `ASU_ADDR_CONFIG, 32'h0);
            xfer(1'b1, `ASU_ADDR_CONFIG, 32'(m * 4 + 3));
            xfer(1'b0, `ASU_ADDR_FLAG, 32'h0);
            xfer(1'b1, `ASU_ADDR_DATA, 32'h1A5);
            u_asu_serial_peer.get(m[2] ? 11 : 10, got);
            chk(got, frm(9'h1A5, 3'(m)));
        end
        rdchk(`ASU_ADDR_FLAG, 32'h18);
        xfer(1'b1, `ASU_ADDR_CONFIG, 32'h0);
        xfer(1'b1, `ASU_ADDR_CONFIG, 32'h43);
        repeat (2) @(posedge clk);
        chk(irq, 32'h1);
        xfer(1'b1, `ASU_ADDR_CONFIG, 32'h3);
        xfer(1'b1, `ASU_ADDR_BAUD, 32'h0);
        xfer(1'b0, `ASU_ADDR_FLAG, 32'h0);
        xfer(1'b1, `ASU_ADDR_DATA, 32'h0F0);
        repeat (100) @(posedge clk);
        chk(txd, 32'h1);
        xfer(1'b1, `ASU_ADDR_BAUD, 32'h1);
        u_asu_serial_peer.get(10, got);
        chk(got, frm(9'h0F0, 3'h0));
        u_asu_serial_peer.send(frm(9'h03C, 3'h0), 10);
        rdchk(`ASU_ADDR_FLAG, 32'h1C);
        rdchk(`ASU_ADDR_DATA, 32'h3C);
        rdchk(`ASU_ADDR_FLAG, 32'h18);
        u_asu_serial_peer.send(frm(9'h011, 3'h0), 10);
        rdchk(`ASU_ADDR_DATA, 32'h11);
        rdchk(`ASU_ADDR_FLAG, 32'h1C);
        u_asu_serial_peer.send(frm(9'h022, 3'h0), 10);
        rdchk(`ASU_ADDR_FLAG, 32'h1E);
        rdchk(`ASU_ADDR_DATA, 32'h11);
        xfer(1'b1, `ASU_ADDR_CONFIG, 32'h0);
        xfer(1'b1, `ASU_ADDR_CONFIG, 32'h0B);
        // The receiver needs three idle samples after enabling before a start bit.
        repeat (16) @(posedge clk);
        u_asu_serial_peer.send(frm(9'h001, 3'h0), 10);
        rdchk(`ASU_ADDR_COMBO, 32'h0001001D);
        rdchk(`ASU_ADDR_FLAG, 32'h18);
        u_asu_serial_peer.send(frm(9'h001, 3'h2), 10);
        rdchk(`ASU_ADDR_COMBO, 32'h0081001C);
        wrap_up();
    end
endmodule : async_serial_interface_tb
`default_nettype wire
